// File: rtl/iec_map.svh
// register layout and timing constants of the interrupt enable control
`ifndef IEC_MAP_SVH
`define IEC_MAP_SVH

`define IEC_ADDR_HI      15
`define IEC_ADDR_LO      14
`define IEC_ADDR_SEL     2'h1
`define IEC_RRS_BIT      13
`define IEC_RO_BIT       12
`define IEC_WDT_EN_BIT   11
`define IEC_OT_EN_BIT    10
`define IEC_GS_EN_BIT    9
`define IEC_CCF_EN_BIT   8
`define IEC_RSVD_BIT     7
`define IEC_VF_EN_BIT    6

`define IEC_FRAME_BITS   5'h10
`define IEC_CNT_MAX      5'h1F
`define IEC_CNT_FIRST    5'h01
`define IEC_RRS_CNT      5'h03
`define IEC_DATA_CNT     5'h04
`define IEC_LAST_IDX     5'h0F

`define IEC_EN_RST       5'h00
`define IEC_DIAG_RST     3'h7
`define IEC_WORD_RST     12'h000
`define IEC_SHIFT_RST    16'h0000

`endif

// File: rtl/iec_pkg.sv
// types shared by the interrupt enable control and its serial link
package iec_pkg;

  typedef struct packed {
    logic wdt;
    logic ot;
    logic gs;
    logic ccf;
    logic vf;
  } iec_en_type;

  typedef struct packed {
    logic wdt;
    logic ot;
    logic gs;
    logic ccf;
    logic vf;
  } iec_irq_type;

  typedef struct packed {
    logic main_regulator_diag;
    logic transceiver_regulator_diag;
    logic third_supply_diag;
  } iec_diag_type;

  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  count;
    logic        read_register_select;
  } iec_link_state_type;

  typedef struct packed {
    logic         csn_s1;
    logic         csn_s2;
    logic         csn_d;
    iec_en_type   en;
    logic         temp_d;
    logic         gs_d;
    iec_diag_type diag_d;
    logic [11:0]  tx_fb;
    logic [11:0]  tx_cause;
    iec_irq_type  ev;
    logic         rst_req;
  } iec_sys_state_type;

endpackage

// File: rtl/iec_spi_link.sv
// serial link end: shift, clock count and readback on the spi clock
`timescale 1ns/1ps
`include "iec_map.svh"

module iec_spi_link (
  input  wire logic        i_spi_clk,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_sdi,
  input  wire logic        i_sys_rst,
  input  wire logic [11:0] i_fb_word,
  input  wire logic [11:0] i_cause_word,
  output logic      [15:0] o_shift,
  output logic      [4:0]  o_count,
  output logic             o_sdo,
  output logic             o_sdo_oe_n
);
  import iec_pkg::*;

  iec_link_state_type st_ff;
  iec_link_state_type nxt_st;
  logic               fresh_ff;
  logic               sdo_ff;
  logic               oe_n_ff;
  logic               out_bit;
  logic [3:0]         idx;

  // spi clock stands still between frames, so frame start is armed by chip select
  always_ff @(posedge i_spi_clk or posedge i_spi_cs_n or posedge i_sys_rst) begin
    if (i_sys_rst || i_spi_cs_n) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.shift = {st_ff.shift[14:0], i_spi_sdi};
    if (fresh_ff) begin
      nxt_st.count = `IEC_CNT_FIRST;
    end else if (st_ff.count != `IEC_CNT_MAX) begin
      nxt_st.count = st_ff.count + `IEC_CNT_FIRST;
    end
    if (nxt_st.count == `IEC_RRS_CNT) begin
      nxt_st.read_register_select = i_spi_sdi;
    end
  end

  always_ff @(posedge i_spi_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '{shift: `IEC_SHIFT_RST, count: 5'h00, read_register_select: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // bits 15..12 answer zero, the data bits come from the selected word
  always_comb begin
    idx = 4'(`IEC_LAST_IDX - st_ff.count);
    out_bit = 1'b0;
    if (st_ff.count >= `IEC_DATA_CNT && st_ff.count < `IEC_FRAME_BITS) begin
      out_bit = st_ff.read_register_select ? i_cause_word[idx] : i_fb_word[idx];
    end
  end

  always_ff @(negedge i_spi_clk or posedge i_spi_cs_n or posedge i_sys_rst) begin
    if (i_sys_rst || i_spi_cs_n) begin
      oe_n_ff <= 1'b1;
      sdo_ff  <= 1'b0;
    end else begin
      oe_n_ff <= 1'b0;
      sdo_ff  <= out_bit;
    end
  end

  assign o_shift    = st_ff.shift;
  assign o_count    = st_ff.count;
  assign o_sdo      = sdo_ff;
  assign o_sdo_oe_n = oe_n_ff;

endmodule

// File: rtl/iec_ctrl.sv
// interrupt enable control: enable register, frame decode and event gating
`timescale 1ns/1ps
`include "iec_map.svh"

// Operation
// - address bits 01 select the enable register
// - select bit 13 picks cause or feedback
// - read-only bit 12 blocks loading the enables
// - watchdog overflow: interrupt if enabled and in standby, else reset
// - temperature warning change interrupts when enabled
// - ground shift change interrupts when enabled
// - bad clock count interrupts when enabled, resets instead when enabled in start-up
// - bad clock count frames are discarded
// - any regulator diagnosis clear interrupts when enabled
// - feedback returns the stored enable bits
// - watchdog overflow clears its own enable
module iec_ctrl (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_spi_clk,
  input  wire logic                  i_spi_cs_n,
  input  wire logic                  i_spi_sdi,
  input  wire logic [11:0]           i_irq_cause,
  input  wire logic                  i_standby,
  input  wire logic                  i_startup_restart,
  input  wire logic                  i_wdt_overflow,
  input  wire logic                  i_temp_warn,
  input  wire logic                  i_gnd_shift,
  input  wire iec_pkg::iec_diag_type i_diag,
  output logic                       o_spi_sdo,
  output logic                       o_spi_sdo_oe_n,
  output iec_pkg::iec_en_type        o_irq_enable,
  output iec_pkg::iec_irq_type       o_irq_event,
  output logic                       o_reset_req
);
  import iec_pkg::*;

  iec_sys_state_type st_ff;
  iec_sys_state_type nxt_st;
  logic [15:0]       link_shift;
  logic [4:0]        link_count;
  logic [11:0]       fb_word;
  logic              frame_end;
  logic              count_ok;
  logic              addr_hit;
  logic              wr_frame;
  logic [2:0]        diag_fall;

  iec_spi_link u_link (
    .i_spi_clk    (i_spi_clk),
    .i_spi_cs_n   (i_spi_cs_n),
    .i_spi_sdi    (i_spi_sdi),
    .i_sys_rst    (i_sys_rst),
    .i_fb_word    (st_ff.tx_fb),
    .i_cause_word (st_ff.tx_cause),
    .o_shift      (link_shift),
    .o_count      (link_count),
    .o_sdo        (o_spi_sdo),
    .o_sdo_oe_n   (o_spi_sdo_oe_n)
  );

  // shift and count are only read after the frame has ended and the spi clock is idle
  assign frame_end = st_ff.csn_s2 & ~st_ff.csn_d;
  assign count_ok  = (link_count == `IEC_FRAME_BITS);
  assign addr_hit  = count_ok &&
                     (link_shift[`IEC_ADDR_HI:`IEC_ADDR_LO] == `IEC_ADDR_SEL);
  assign wr_frame  = frame_end && addr_hit && !link_shift[`IEC_RO_BIT];
  assign diag_fall = st_ff.diag_d & ~i_diag;

  // reserved bit reads as zero, whatever the master sent in it
  always_comb begin
    fb_word = `IEC_WORD_RST;
    fb_word[`IEC_WDT_EN_BIT] = st_ff.en.wdt;
    fb_word[`IEC_OT_EN_BIT]  = st_ff.en.ot;
    fb_word[`IEC_GS_EN_BIT]  = st_ff.en.gs;
    fb_word[`IEC_CCF_EN_BIT] = st_ff.en.ccf;
    fb_word[`IEC_VF_EN_BIT]  = st_ff.en.vf;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.csn_s1 = i_spi_cs_n;
    nxt_st.csn_s2 = st_ff.csn_s1;
    nxt_st.csn_d  = st_ff.csn_s2;
    nxt_st.temp_d = i_temp_warn;
    nxt_st.gs_d   = i_gnd_shift;
    nxt_st.diag_d = i_diag;
    nxt_st.ev     = '0;
    nxt_st.rst_req = 1'b0;

    // readback words frozen while a frame runs, so the link sees a stable value
    if (st_ff.csn_s2) begin
      nxt_st.tx_fb    = fb_word;
      nxt_st.tx_cause = i_irq_cause;
    end

    if (wr_frame) begin
      nxt_st.en.wdt = link_shift[`IEC_WDT_EN_BIT];
      nxt_st.en.ot  = link_shift[`IEC_OT_EN_BIT];
      nxt_st.en.gs  = link_shift[`IEC_GS_EN_BIT];
      nxt_st.en.ccf = link_shift[`IEC_CCF_EN_BIT];
      nxt_st.en.vf  = link_shift[`IEC_VF_EN_BIT];
    end

    // fail-safe: the overflow clear beats a write landing in the same cycle
    if (i_wdt_overflow) begin
      nxt_st.en.wdt = 1'b0;
      if (i_standby && st_ff.en.wdt) begin
        nxt_st.ev.wdt = 1'b1;
      end else begin
        nxt_st.rst_req = 1'b1;
      end
    end

    nxt_st.ev.ot = st_ff.en.ot & (i_temp_warn ^ st_ff.temp_d);
    nxt_st.ev.gs = st_ff.en.gs & (i_gnd_shift ^ st_ff.gs_d);
    nxt_st.ev.vf = st_ff.en.vf & (|diag_fall);

    // a wrong clock count never reaches the register, only the failure path
    if (frame_end && !count_ok && st_ff.en.ccf) begin
      if (i_startup_restart) begin
        nxt_st.rst_req = 1'b1;
      end else begin
        nxt_st.ev.ccf = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff          <= '0;
      st_ff.csn_s1   <= 1'b1;
      st_ff.csn_s2   <= 1'b1;
      st_ff.csn_d    <= 1'b1;
      st_ff.en       <= `IEC_EN_RST;
      st_ff.diag_d   <= `IEC_DIAG_RST;
      st_ff.tx_fb    <= `IEC_WORD_RST;
      st_ff.tx_cause <= `IEC_WORD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_irq_enable = st_ff.en;
  assign o_irq_event  = st_ff.ev;
  assign o_reset_req  = st_ff.rst_req;

  // checks on the register, the frame decode and the event paths

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  addr_select_a: assert property (
    frame_end && count_ok && !i_wdt_overflow &&
    link_shift[`IEC_ADDR_HI:`IEC_ADDR_LO] != `IEC_ADDR_SEL
    |=> o_irq_enable == $past(o_irq_enable))
    else $error("enables changed by a frame for another address");

  write_load_a: assert property (
    wr_frame && !i_wdt_overflow
    |=> o_irq_enable.wdt == $past(link_shift[`IEC_WDT_EN_BIT]) &&
        o_irq_enable.ot  == $past(link_shift[`IEC_OT_EN_BIT]) &&
        o_irq_enable.gs  == $past(link_shift[`IEC_GS_EN_BIT]) &&
        o_irq_enable.ccf == $past(link_shift[`IEC_CCF_EN_BIT]) &&
        o_irq_enable.vf  == $past(link_shift[`IEC_VF_EN_BIT]))
    else $error("write frame did not load the enables");

  read_only_a: assert property (
    frame_end && link_shift[`IEC_RO_BIT] && !i_wdt_overflow
    |=> $stable(o_irq_enable))
    else $error("read-only frame altered the enables");

  enable_hold_a: assert property (
    !wr_frame && !i_wdt_overflow |=> $stable(o_irq_enable))
    else $error("enables changed without a write frame");

  wdt_irq_a: assert property (
    i_wdt_overflow && i_standby && o_irq_enable.wdt
    |=> o_irq_event.wdt && !o_reset_req)
    else $error("watchdog overflow did not give an interrupt");

  wdt_reset_a: assert property (
    i_wdt_overflow && !(i_standby && o_irq_enable.wdt)
    |=> o_reset_req && !o_irq_event.wdt)
    else $error("watchdog overflow did not give a reset");

  wdt_clear_a: assert property (
    i_wdt_overflow |=> !o_irq_enable.wdt ##1 !o_irq_enable.wdt || $past(wr_frame))
    else $error("watchdog enable survived an overflow");

  temp_event_a: assert property (
    (i_temp_warn != $past(i_temp_warn)) && o_irq_enable.ot
    |=> o_irq_event.ot)
    else $error("temperature change gave no interrupt");

  temp_quiet_a: assert property (
    o_irq_event.ot |-> $past(o_irq_enable.ot) &&
                       $past(i_temp_warn) != $past(i_temp_warn, 2))
    else $error("temperature interrupt without cause or enable");

  gnd_event_a: assert property (
    (i_gnd_shift != $past(i_gnd_shift)) && o_irq_enable.gs
    |=> o_irq_event.gs)
    else $error("ground shift change gave no interrupt");

  gnd_quiet_a: assert property (
    !o_irq_enable.gs |=> !o_irq_event.gs)
    else $error("ground shift interrupt while disabled");

  ccf_irq_a: assert property (
    frame_end && !count_ok && o_irq_enable.ccf && !i_startup_restart
    |=> o_irq_event.ccf)
    else $error("clock count failure gave no interrupt");

  ccf_reset_a: assert property (
    frame_end && !count_ok && o_irq_enable.ccf && i_startup_restart
    |=> o_reset_req && !o_irq_event.ccf)
    else $error("clock count failure in start-up gave no reset");

  ccf_discard_a: assert property (
    frame_end && !count_ok && !i_wdt_overflow
    |=> $stable(o_irq_enable) && (o_irq_event.ccf == $past(o_irq_enable.ccf) ||
                                  $past(i_startup_restart)))
    else $error("bad frame was not discarded");

  volt_event_a: assert property (
    (|($past(i_diag) & ~i_diag)) && o_irq_enable.vf |=> o_irq_event.vf)
    else $error("regulator diagnosis clear gave no interrupt");

  volt_quiet_a: assert property (
    o_irq_event.vf |-> $past(o_irq_enable.vf))
    else $error("voltage interrupt while disabled");

  feedback_a: assert property (
    st_ff.csn_s2 && $stable(o_irq_enable) ##1 $stable(o_irq_enable)
    |-> st_ff.tx_fb[`IEC_WDT_EN_BIT] == o_irq_enable.wdt &&
        st_ff.tx_fb[`IEC_VF_EN_BIT] == o_irq_enable.vf &&
        !st_ff.tx_fb[`IEC_RSVD_BIT])
    else $error("feedback word does not match the enables");

  feedback_mid_a: assert property (
    st_ff.csn_s2 && $stable(o_irq_enable) ##1 $stable(o_irq_enable)
    |-> st_ff.tx_fb[`IEC_OT_EN_BIT] == o_irq_enable.ot &&
        st_ff.tx_fb[`IEC_GS_EN_BIT] == o_irq_enable.gs &&
        st_ff.tx_fb[`IEC_CCF_EN_BIT] == o_irq_enable.ccf)
    else $error("feedback word misses an enable bit");

  readback_freeze_a: assert property (
    !st_ff.csn_s2 |=> $stable(st_ff.tx_fb) && $stable(st_ff.tx_cause))
    else $error("readback word moved during a frame");

  cause_copy_a: assert property (
    st_ff.csn_s2 |=> st_ff.tx_cause == $past(i_irq_cause))
    else $error("cause word not taken while idle");

  sdo_idle_a: assert property (
    st_ff.csn_s1 && st_ff.csn_s2 |-> o_spi_sdo_oe_n && !o_spi_sdo)
    else $error("data line driven outside a frame");

  ot_silent_a: assert property (
    !o_irq_enable.ot |=> !o_irq_event.ot)
    else $error("temperature interrupt while disabled");

  volt_silent_a: assert property (
    !o_irq_enable.vf |=> !o_irq_event.vf)
    else $error("voltage interrupt while its enable is clear");

  gnd_cause_a: assert property (
    o_irq_event.gs |-> $past(o_irq_enable.gs) &&
                       $past(i_gnd_shift) != $past(i_gnd_shift, 2))
    else $error("ground shift interrupt without a change");

  volt_cause_a: assert property (
    o_irq_event.vf |-> |($past(i_diag, 2) & ~$past(i_diag)))
    else $error("voltage interrupt without a diagnosis clear");

  ccf_silent_a: assert property (
    !(frame_end && !count_ok && o_irq_enable.ccf) |=> !o_irq_event.ccf)
    else $error("clock count interrupt without a bad frame");

  ccf_cause_a: assert property (
    o_irq_event.ccf |-> $past(o_irq_enable.ccf) && !$past(i_startup_restart))
    else $error("clock count interrupt in start-up or while disabled");

  wdt_cause_a: assert property (
    o_irq_event.wdt |-> $past(i_wdt_overflow) && $past(i_standby) &&
                        $past(o_irq_enable.wdt))
    else $error("watchdog interrupt without an enabled overflow");

  reset_cause_a: assert property (
    o_reset_req |-> $past(i_wdt_overflow) ||
                    $past(frame_end && !count_ok && o_irq_enable.ccf && i_startup_restart))
    else $error("reset request without a cause");

endmodule

// File: test/iec_spi_master.sv
// spi master model standing in for the microcontroller
`timescale 1ns/1ps

module iec_spi_master (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  initial begin
    o_sck  = 1'h0;
    o_cs_n = 1'h1;
    o_mosi = 1'h0;
  end

  // n other than 16 only where a test wants the frame refused
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    o_cs_n = 1'h0;
    #24;
    for (int k = 0; k < n; k++) begin
      o_mosi = (k < 16) ? w[15-k] : 1'h0;
      #24 o_sck = 1'h1;
      r = {r[14:0], i_miso};
      #24 o_sck = 1'h0;
    end
    #24 o_cs_n = 1'h1;
    // released line must not keep showing the last bit
    o_mosi = ~o_mosi;
    #120;
  endtask
endmodule

// File: test/interrupt_enable_control_tb_top.sv
// self-checking bench of the interrupt enable control
`timescale 1ns/1ps
`define CHK(a, e, s) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("MISMATCH t=%0t %s", $time, s); \
  end \
end

module interrupt_enable_control_tb_top;
  import iec_pkg::*;
  logic         i_clk;
  logic         i_sys_rst;
  logic         sck, cs_n, mosi;
  logic [11:0]  i_irq_cause;
  logic         i_standby, i_startup_restart, i_wdt_overflow, i_temp_warn, i_gnd_shift;
  iec_diag_type i_diag;
  logic         o_spi_sdo, o_spi_sdo_oe_n, o_reset_req;
  iec_en_type   o_irq_enable;
  iec_irq_type  o_irq_event;
  logic [4:0]   m;
  logic [15:0]  rd;
  int           n_mismatch, comparisons;
  int           cnt[6], c0[6];
  // released miso reads as pulled low
  wire          miso = o_spi_sdo_oe_n ? 1'h0 : o_spi_sdo;

  iec_ctrl i_iec_ctrl (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_spi_clk(sck), .i_spi_cs_n(cs_n),
    .i_spi_sdi(mosi), .i_irq_cause(i_irq_cause), .i_standby(i_standby),
    .i_startup_restart(i_startup_restart), .i_wdt_overflow(i_wdt_overflow),
    .i_temp_warn(i_temp_warn), .i_gnd_shift(i_gnd_shift), .i_diag(i_diag),
    .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe_n(o_spi_sdo_oe_n), .o_irq_enable(o_irq_enable),
    .o_irq_event(o_irq_event), .o_reset_req(o_reset_req)
  );

  iec_spi_master i_iec_spi_master (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));

  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end

  // pulse tallies: wdt, ot, gs, ccf, vf, reset request
  always @(posedge i_clk) begin
    for (int k = 0; k < 5; k++) begin
      cnt[k] <= cnt[k] + int'(o_irq_event[4-k]);
    end
    cnt[5] <= cnt[5] + int'(o_reset_req);
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic snap();
    @(negedge i_clk);
    c0 = cnt;
  endtask

  task automatic chk_ev(input int e[6], input string s);
    @(negedge i_clk);
    for (int k = 0; k < 6; k++) begin
      `CHK(cnt[k] - c0[k], e[k], s)
    end
  endtask

  task automatic drive(input logic t, input logic g, input logic [2:0] d, input logic w);
    @(posedge i_clk);
    i_temp_warn    <= t;
    i_gnd_shift    <= g;
    i_diag         <= d;
    i_wdt_overflow <= w;
    @(posedge i_clk);
    i_wdt_overflow <= 1'h0;
    repeat (3) @(posedge i_clk);
  endtask

  // model: enables land only after the frame, readback shows the old set
  task automatic wr(input logic [1:0] a, input logic sel, input logic ro, input logic [4:0] en);
    logic [15:0] w;
    logic [15:0] ex;
    w  = {a, sel, ro, en[4:1], 1'h0, en[0], 6'h00};
    ex = {4'h0, sel ? i_irq_cause : {m[4:1], 1'h0, m[0], 6'h00}};
    i_iec_spi_master.xfer(w, 16, rd);
    `CHK(rd, ex, "readback word")
    if (a == 2'h1 && !ro) m = en;
    `CHK(o_irq_enable, m, "stored enables")
  endtask

  initial begin
    #200000;
    n_mismatch++;
    $display("MISMATCH t=%0t run timed out", $time);
    complete_run();
  end

  initial begin
    i_sys_rst = 1'h1;
    i_irq_cause = 12'h000;
    i_standby = 1'h0;
    i_startup_restart = 1'h0;
    i_wdt_overflow = 1'h0;
    i_temp_warn = 1'h0;
    i_gnd_shift = 1'h0;
    i_diag = 3'h7;
    m = 5'h00;
    void'($urandom(32'hE6D3));
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    repeat (4) @(posedge i_clk);
    `CHK(o_irq_enable, 5'h00, "enables after reset")
    `CHK(o_irq_event, 5'h00, "no events after reset")
    $display("test reset done");

    for (int i = 0; i < 12; i++) begin
      @(posedge i_clk);
      i_irq_cause <= 12'($urandom());
      @(negedge i_clk);
      wr((i < 4) ? 2'h1 : 2'($urandom()), 1'($urandom()), (i < 4) ? 1'h0 : 1'($urandom()),
         5'($urandom()));
    end
    $display("test frames done");

    for (int on = 1; on >= 0; on--) begin
      wr(2'h1, 1'h0, 1'h0, {1'h0, on[0], on[0], 1'h0, on[0]});
      snap();
      drive(1'h1, 1'h0, 3'h7, 1'h0);
      drive(1'h0, 1'h1, 3'h7, 1'h0);
      drive(1'h0, 1'h1, 3'h5, 1'h0);
      drive(1'h0, 1'h0, 3'h7, 1'h0);
      chk_ev('{0, 2*on, 2*on, 0, on, 0}, "source events");
    end
    $display("test events done");

    for (int i = 0; i < 3; i++) begin
      wr(2'h1, 1'h0, 1'h0, {3'h0, 1'(i < 2), 1'h0});
      @(posedge i_clk);
      i_startup_restart <= (i == 1);
      snap();
      i_iec_spi_master.xfer(16'h4F40, (i == 1) ? 17 : 15, rd);
      `CHK(o_irq_enable, m, "bad count frame ignored")
      chk_ev('{0, 0, 0, i == 0, 0, i == 1}, "count failure");
    end
    @(posedge i_clk);
    i_startup_restart <= 1'h0;
    $display("test count done");

    for (int i = 0; i < 3; i++) begin
      wr(2'h1, 1'h0, 1'h0, {1'(i != 1), 4'h0});
      @(posedge i_clk);
      i_standby <= (i != 2);
      snap();
      drive(1'h0, 1'h0, 3'h7, 1'h1);
      m[4] = 1'h0;
      `CHK(o_irq_enable, m, "watchdog enable self clear")
      chk_ev('{i == 0, 0, 0, 0, 0, i != 0}, "watchdog outcome");
    end
    $display("test watchdog done");
    complete_run();
  end
endmodule
